// ===== verilog/brw_decode.v
`timescale 1ns/1ps
// Behaviour
// - base bits compare with address bits 31:20, low bits ignored per size
// - reset loads block B base ff4, block A base ff0
// - size code 000..110 means 1 MB..64 MB, 111 reserved
// - width bit clear means 16-bit block, set means 64-bit block
// - width bit taken from its strap at power-up, read-only afterwards
// - top megabyte goes to B if its vector bit set, else A, else none
// - vector block's first megabyte also answers at the top of map
// - vector bits loaded from own straps at power-up, software writable
// - base range answers only while the block enable bit is set
// - valid write with write enable clear ends normally, flash not written
// - byte writes on 16-bit blocks, aligned word writes on 64-bit blocks
// - misaligned, wrong-size or other-size writes get no response
`include "brw_defines.vh"

module brw_decode (
  input  wire        clk_i,          // bus clock, 125 MHz
  input  wire        ce_i,           // clock enable, freezes all state when low
  input  wire        nrst_i,         // power-up reset, synchronous, active low
  input  wire        lb_rst_n_i,     // local bus reset, synchronous, active low
  input  wire        strap_vector_a, // vector source strap for block A
  input  wire        strap_vector_b, // vector source strap for block B
  input  wire        strap_width_a,  // width strap for block A
  input  wire        strap_width_b,  // width strap for block B
  input  wire [31:0] reg_addr_i,     // register byte address
  input  wire [31:0] reg_wdata_i,    // register write data
  input  wire        reg_we_i,       // register write strobe
  input  wire        reg_re_i,       // register read strobe
  output wire [31:0] reg_rdata_o,    // register read data, cycle after strobe
  input  wire        acc_valid_i,    // processor access request
  input  wire [31:0] acc_addr_i,     // processor address
  input  wire        acc_write_i,    // access is a write
  input  wire [5:0]  acc_size_i,     // transfer size in bytes
  output wire        acc_ack_o,      // normal termination pulse
  output wire        sel_a_o,        // access decoded to block A
  output wire        sel_b_o,        // access decoded to block B
  output wire        sel_wide_o,     // selected block is 64 bits wide
  output wire        flash_wr_o,     // write really goes to the flash
  output wire [31:0] flash_addr_o    // address offset inside the block
);

  // size code to a mask of compared base bits
  function [11:0] size_mask;
    input [2:0] siz;
    begin
      case (siz)
        `BRW_SIZ_RSVD: begin
          size_mask = `BRW_BASE_ONES; // reserved code never reaches a compare
        end
        default: begin
          size_mask = `BRW_BASE_ONES << siz;
        end
      endcase
    end
  endfunction

  // base range hit for one block
  function base_hit;
    input [11:0] page;
    input [11:0] base;
    input [2:0]  siz;
    input        en;
    reg   [11:0] m;
    begin
      m = size_mask(siz);
      base_hit = en && (siz != `BRW_SIZ_RSVD) && ((page & m) == (base & m));
    end
  endfunction

  // write legality for a block of the given width
  function write_ok;
    input       wide;
    input [5:0] sz;
    input [1:0] lo;
    begin
      if (wide) begin
        write_ok = (sz == `BRW_SZ_WORD) && (lo == `BRW_ALIGN_MASK);
      end else begin
        write_ok = (sz == `BRW_SZ_BYTE);
      end
    end
  endfunction

  // register image of one block
  function [31:0] pack_reg;
    input [11:0] base;
    input        wide;
    input [2:0]  siz;
    input        rv;
    input        en;
    input        we;
    reg   [31:0] r;
    begin
      r = 32'h0;
      r[`BRW_BASE_HI:`BRW_BASE_LO] = base;
      r[`BRW_W64_BIT] = wide;
      r[`BRW_SIZ_HI:`BRW_SIZ_LO] = siz;
      r[`BRW_RV_BIT] = rv;
      r[`BRW_EN_BIT] = en;
      r[`BRW_WE_BIT] = we;
      pack_reg = r;
    end
  endfunction

  // full address match on the register port
  function reg_match;
    input [31:0] addr;
    input [31:0] target;
    begin
      reg_match = (addr == target);
    end
  endfunction

  // vector source from the two vector bits, as {block a, block b}
  function [1:0] vec_pick;
    input rv_a;
    input rv_b;
    begin
      case ({rv_a, rv_b})
        2'h0: begin
          vec_pick = 2'h0;
        end
        2'h1: begin
          vec_pick = 2'h1;
        end
        2'h2: begin
          vec_pick = 2'h2;
        end
        2'h3: begin
          vec_pick = 2'h1;
        end
        default: begin
          vec_pick = 2'h0;
        end
      endcase
    end
  endfunction

  wire [`BRW_STRAP_W-1:0] strap_s;

  brw_sync2 #(
    .W (`BRW_STRAP_W)
  ) u_strap_sync (
    .clk_i (clk_i),
    .ce_i  (ce_i),
    .d_i   ({strap_width_b, strap_width_a, strap_vector_b, strap_vector_a}),
    .q_o   (strap_s)
  );

  // synchronised straps, named by what they preset
  wire strap_va_s = strap_s[`BRW_STRAP_VA];
  wire strap_vb_s = strap_s[`BRW_STRAP_VB];
  wire strap_wa_s = strap_s[`BRW_STRAP_WA];
  wire strap_wb_s = strap_s[`BRW_STRAP_WB];

  reg [11:0] base_a_q;
  reg [11:0] base_b_q;
  reg [2:0]  siz_a_q;
  reg [2:0]  siz_b_q;
  reg        en_a_q;
  reg        en_b_q;
  reg        we_a_q;
  reg        we_b_q;
  reg        block_a_vector_source_q;
  reg        block_b_vector_source_q;
  reg        wide_a_q;
  reg        wide_b_q;
  reg [31:0] rdata_q;

  wire wr_a = reg_we_i && reg_match(reg_addr_i, `BRW_A_REG_ADDR);
  wire wr_b = reg_we_i && reg_match(reg_addr_i, `BRW_B_REG_ADDR);
  wire rd_a = reg_re_i && reg_match(reg_addr_i, `BRW_A_REG_ADDR);
  wire rd_b = reg_re_i && reg_match(reg_addr_i, `BRW_B_REG_ADDR);

  // straps and vector bits: power-up reset only
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (!nrst_i) begin
        wide_a_q                <= strap_wa_s;
        wide_b_q                <= strap_wb_s;
        block_a_vector_source_q <= strap_va_s;
        block_b_vector_source_q <= strap_vb_s;
      end else begin
        if (wr_a) begin
          block_a_vector_source_q <= reg_wdata_i[`BRW_RV_BIT];
        end
        if (wr_b) begin
          block_b_vector_source_q <= reg_wdata_i[`BRW_RV_BIT];
        end
      end
    end
  end

  // base, size, enables: power-up or local bus reset
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (!nrst_i || !lb_rst_n_i) begin
        base_a_q <= `BRW_A_BASE_RST;
        base_b_q <= `BRW_B_BASE_RST;
        siz_a_q  <= `BRW_SIZ_RST;
        siz_b_q  <= `BRW_SIZ_RST;
        en_a_q   <= 1'b0;
        en_b_q   <= 1'b0;
        we_a_q   <= 1'b0;
        we_b_q   <= 1'b0;
      end else begin
        if (wr_a) begin
          base_a_q <= reg_wdata_i[`BRW_BASE_HI:`BRW_BASE_LO];
          siz_a_q  <= reg_wdata_i[`BRW_SIZ_HI:`BRW_SIZ_LO];
          en_a_q   <= reg_wdata_i[`BRW_EN_BIT];
          we_a_q   <= reg_wdata_i[`BRW_WE_BIT];
        end
        if (wr_b) begin
          base_b_q <= reg_wdata_i[`BRW_BASE_HI:`BRW_BASE_LO];
          siz_b_q  <= reg_wdata_i[`BRW_SIZ_HI:`BRW_SIZ_LO];
          en_b_q   <= reg_wdata_i[`BRW_EN_BIT];
          we_b_q   <= reg_wdata_i[`BRW_WE_BIT];
        end
      end
    end
  end

  // next read word: zero unless a mapped register is read this cycle
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h0;
    if (rd_a) begin
      rdata_d = pack_reg(base_a_q, wide_a_q, siz_a_q, block_a_vector_source_q,
                         en_a_q, we_a_q);
    end else if (rd_b) begin
      rdata_d = pack_reg(base_b_q, wide_b_q, siz_b_q, block_b_vector_source_q,
                         en_b_q, we_b_q);
    end
  end

  // read data stand only in the cycle after the read strobe
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (!nrst_i) begin
        rdata_q <= 32'h0;
      end else begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata_o = rdata_q;

  // address decode
  reg  [11:0] page;
  reg         vec_page;
  reg  [1:0]  vec_sel;
  reg         hit_a;
  reg         hit_b;
  reg         hit_any;
  reg         hit_wide;
  reg         hit_we;
  reg         wr_legal;
  reg         resp;
  reg         wr_flash;
  reg  [11:0] off_mask;
  reg  [31:0] offset;

  // the vector page overrides the base decode there, enable bits included
  always @* begin
    page     = acc_addr_i[`BRW_PAGE_HI:`BRW_PAGE_LO];
    vec_page = (page == `BRW_VEC_PAGE);
    vec_sel  = vec_pick(block_a_vector_source_q, block_b_vector_source_q);
    if (vec_page) begin
      hit_a = vec_sel[1];
      hit_b = vec_sel[0];
    end else begin
      hit_a = base_hit(page, base_a_q, siz_a_q, en_a_q);
      hit_b = base_hit(page, base_b_q, siz_b_q, en_b_q);
    end
    // overlapping base ranges break a software rule; block b wins then
    if (hit_b) begin
      hit_a    = 1'b0;
      hit_wide = wide_b_q;
      hit_we   = we_b_q;
      off_mask = size_mask(siz_b_q);
    end else begin
      hit_wide = wide_a_q;
      hit_we   = we_a_q;
      off_mask = size_mask(siz_a_q);
    end
    // the vector alias maps onto the first megabyte of its block
    if (vec_page) begin
      off_mask = `BRW_BASE_ONES;
    end
    hit_any  = hit_a || hit_b;
    offset   = {page & ~off_mask, acc_addr_i[`BRW_OFF_HI:`BRW_OFF_LO]};
    wr_legal = write_ok(hit_wide, acc_size_i, acc_addr_i[`BRW_ALIGN_HI:`BRW_OFF_LO]);
    // no response at all unless the block is hit and a write suits its width
    resp     = acc_valid_i && hit_any && (!acc_write_i || wr_legal);
    wr_flash = resp && acc_write_i && hit_we;
  end

  // selects and width only accompany a normal termination
  wire sel_a_d = resp && hit_a;
  wire sel_b_d = resp && hit_b;
  wire wide_d  = resp && hit_wide;

  reg        ack_q;
  reg        sel_a_q;
  reg        sel_b_q;
  reg        wide_q;
  reg        flash_wr_q;
  reg [31:0] faddr_q;

  always @(posedge clk_i) begin
    if (ce_i) begin
      if (!nrst_i || !lb_rst_n_i) begin
        ack_q      <= 1'b0;
        sel_a_q    <= 1'b0;
        sel_b_q    <= 1'b0;
        wide_q     <= 1'b0;
        flash_wr_q <= 1'b0;
        faddr_q    <= 32'h0;
      end else begin
        ack_q      <= resp;
        flash_wr_q <= wr_flash;
        sel_a_q    <= sel_a_d;
        sel_b_q    <= sel_b_d;
        wide_q     <= wide_d;
        if (acc_valid_i && hit_any) begin
          faddr_q <= offset;
        end
      end
    end
  end

  assign acc_ack_o    = ack_q;
  assign sel_a_o      = sel_a_q;
  assign sel_b_o      = sel_b_q;
  assign sel_wide_o   = wide_q;
  assign flash_wr_o   = flash_wr_q;
  assign flash_addr_o = faddr_q;

endmodule // brw_decode

// ===== verilog/brw_defines.vh
`ifndef BRW_DEFINES_VH
`define BRW_DEFINES_VH

// register byte addresses on the software port
`define BRW_A_REG_ADDR   32'hfef80050
`define BRW_B_REG_ADDR   32'hfef80058

// field positions inside a base/size register (bit 31 is the msb)
`define BRW_BASE_HI      31
`define BRW_BASE_LO      20
`define BRW_W64_BIT      19
`define BRW_SIZ_HI       18
`define BRW_SIZ_LO       16
`define BRW_RV_BIT       2
`define BRW_EN_BIT       1
`define BRW_WE_BIT       0

// reset values
`define BRW_A_BASE_RST   12'hff0
`define BRW_B_BASE_RST   12'hff4
`define BRW_SIZ_RST      3'h0
`define BRW_SIZ_RSVD     3'h7

// top-of-map vector page, address bits 31:20
`define BRW_VEC_PAGE     12'hfff
`define BRW_BASE_ONES    12'hfff

// processor address fields: page compared with the base, offset inside a megabyte
`define BRW_PAGE_HI      31
`define BRW_PAGE_LO      20
`define BRW_OFF_HI       19
`define BRW_OFF_LO       0
`define BRW_ALIGN_HI     1

// transfer sizes in bytes
`define BRW_SZ_BYTE      6'h01
`define BRW_SZ_WORD      6'h04
`define BRW_ALIGN_MASK   2'h0

`define BRW_STRAP_W      4
`define BRW_STRAP_VA     0
`define BRW_STRAP_VB     1
`define BRW_STRAP_WA     2
`define BRW_STRAP_WB     3

`endif

// ===== verilog/brw_sync2.v
`timescale 1ns/1ps
// two-flop synchroniser for strap pins
module brw_sync2 #(
  parameter W = 4
) (
  input  wire         clk_i,  // bus clock
  input  wire         ce_i,   // clock enable
  input  wire [W-1:0] d_i,    // asynchronous input
  output wire [W-1:0] q_o     // synchronised output
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_i) begin
    if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule // brw_sync2

// ===== tb/brw_decode_asserts.sv
`timescale 1ns/1ps
module brw_decode_asserts (
  input wire        clk_i,       // clock
  input wire        nrst_i,      // reset
  input wire        acc_valid_i, // request
  input wire [31:0] acc_addr_i,  // address
  input wire        acc_write_i, // write flag
  input wire [5:0]  acc_size_i,  // size
  input wire        acc_ack_o,   // ack
  input wire        sel_a_o,     // block a
  input wire        sel_b_o,     // block b
  input wire        sel_wide_o,  // wide block
  input wire        flash_wr_o   // flash write
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_ack_cause; acc_ack_o |-> $past(acc_valid_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_bad_size; acc_valid_i && acc_write_i && acc_size_i != 6'h01 && acc_size_i != 6'h04 |=> !acc_ack_o; endproperty
  a_bad_size: assert property (p_bad_size) else $error("odd size write answered");
  property p_misalign; acc_valid_i && acc_write_i && acc_size_i == 6'h04 && acc_addr_i[1:0] != 2'h0 |=> !acc_ack_o; endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned write answered");
  property p_wr_gate; flash_wr_o |-> acc_ack_o && $past(acc_write_i); endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("flash write without write cycle");
  property p_wide_wr; acc_ack_o && sel_wide_o && $past(acc_write_i) |-> $past(acc_size_i) == 6'h04; endproperty
  a_wide_wr: assert property (p_wide_wr) else $error("wide block took bad size");
  property p_narrow_wr; acc_ack_o && !sel_wide_o && $past(acc_write_i) |-> $past(acc_size_i) == 6'h01; endproperty
  a_narrow_wr: assert property (p_narrow_wr) else $error("narrow block took bad size");
  property p_one_blk; acc_ack_o |-> sel_a_o ^ sel_b_o; endproperty
  a_one_blk: assert property (p_one_blk) else $error("not one block selected");
  property p_sel_ack; sel_a_o || sel_b_o |-> acc_ack_o; endproperty
  a_sel_ack: assert property (p_sel_ack) else $error("select without ack");
endmodule // brw_decode_asserts
bind brw_decode brw_decode_asserts brw_decode_asserts_i (.clk_i, .nrst_i, .acc_valid_i,
  .acc_addr_i, .acc_write_i, .acc_size_i, .acc_ack_o, .sel_a_o, .sel_b_o, .sel_wide_o,
  .flash_wr_o);

// ===== tb/brw_master.sv
`timescale 1ns/1ps
module brw_master (
  input  wire        clk_i,        // clock
  output reg         acc_valid_o,  // request
  output reg  [31:0] acc_addr_o,   // address
  output reg         acc_write_o,  // write flag
  output reg  [5:0]  acc_size_o,   // size
  input  wire [4:0]  rsp_i,        // ack, sel a, sel b, wide, flash write
  input  wire [31:0] flash_addr_i  // offset
);
  reg [4:0]  rsp_q;
  reg [31:0] off_q;
  initial begin
    acc_valid_o = 1'b0;
    acc_addr_o = 32'h0;
    acc_write_o = 1'b0;
    acc_size_o = 6'h0;
  end
  // one access at a time, never overlapping a register write
  task acc(input [31:0] a, input w, input [5:0] s);
    begin
      @(posedge clk_i);
      acc_valid_o <= 1'b1;
      acc_addr_o <= a;
      acc_write_o <= w;
      acc_size_o <= s;
      @(posedge clk_i);
      acc_valid_o <= 1'b0;
      acc_addr_o <= ~a;
      #1;
      rsp_q = rsp_i;
      off_q = flash_addr_i;
    end
  endtask
endmodule // brw_master

// ===== tb/test_boot_rom_window_decode.sv
`timescale 1ns/1ps
`include "brw_defines.vh"
module test_boot_rom_window_decode;
  reg         clk_i, nrst_i, lb_rst_n_i, reg_we_i, reg_re_i, ok;
  reg  [31:0] reg_addr_i, reg_wdata_i;
  wire [31:0] reg_rdata_o, acc_addr, faddr;
  wire        acc_valid, acc_write, ack, sa, sb, sw, fw;
  wire [5:0]  acc_size;
  integer     error_cnt, total_checks, i, k;
  reg  [53:0] szt = {6'h20, 6'h08, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01};
  brw_decode brw_decode_i (.clk_i(clk_i), .ce_i(1'b1), .nrst_i(nrst_i), .lb_rst_n_i(lb_rst_n_i),
    .strap_vector_a(1'b1), .strap_vector_b(1'b0), .strap_width_a(1'b0), .strap_width_b(1'b1),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .acc_valid_i(acc_valid), .acc_addr_i(acc_addr),
    .acc_write_i(acc_write), .acc_size_i(acc_size), .acc_ack_o(ack), .sel_a_o(sa), .sel_b_o(sb),
    .sel_wide_o(sw), .flash_wr_o(fw), .flash_addr_o(faddr));
  brw_master brw_master_i (.clk_i(clk_i), .acc_valid_o(acc_valid), .acc_addr_o(acc_addr),
    .acc_write_o(acc_write), .acc_size_o(acc_size), .rsp_i({ack, sa, sb, sw, fw}),
    .flash_addr_i(faddr));
  function [31:0] img(input [11:0] b, input [2:0] s, input rv, input en, input we);
    img = {b, 1'b0, s, 13'h0, rv, en, we};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      repeat (2) @(posedge clk_i);
      reg_re_i <= 1'b0;
      reg_we_i <= 1'b1;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
      reg_re_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reg_re_i <= 1'b0;
    end
  endtask
  task rdc(input [31:0] a, input [31:0] exp);
    begin
      @(posedge clk_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
    end
  endtask
  task ac(input [31:0] a, input w, input [5:0] s, input [4:0] exp);
    begin
      brw_master_i.acc(a, w, s);
      chk({27'h0, brw_master_i.rsp_q}, {27'h0, exp});
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    test_done;
  end
  initial begin
    error_cnt = 0;
    total_checks = 0;
    {nrst_i, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} = 0;
    lb_rst_n_i = 1'b1;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdc(`BRW_A_REG_ADDR, 32'hff000004);
    rdc(`BRW_B_REG_ADDR, 32'hff480000);
    rdc(32'hfef80054, 32'h0);
    ac(32'hfff00010, 1'b0, 6'h08, 5'h18);
    chk(brw_master_i.off_q, 32'h10);
    wr(`BRW_B_REG_ADDR, img(12'hff4, 3'h0, 1'b1, 1'b0, 1'b0));
    ac(32'hfff00020, 1'b0, 6'h04, 5'h16);
    rdc(`BRW_B_REG_ADDR, 32'hff480004);
    ac(32'hff400000, 1'b0, 6'h04, 5'h00);
    wr(`BRW_A_REG_ADDR, img(12'hff0, 3'h0, 1'b0, 1'b0, 1'b0));
    wr(`BRW_B_REG_ADDR, img(12'hff5, 3'h2, 1'b0, 1'b1, 1'b0));
    ac(32'hfff00020, 1'b0, 6'h04, 5'h00);
    ac(32'hff400000, 1'b0, 6'h04, 5'h16);
    ac(32'hff7fff00, 1'b0, 6'h01, 5'h16);
    chk(brw_master_i.off_q, 32'h3fff00);
    ac(32'hff800000, 1'b0, 6'h01, 5'h00);
    wr(`BRW_B_REG_ADDR, img(12'hff4, 3'h7, 1'b0, 1'b1, 1'b0));
    ac(32'hff400000, 1'b0, 6'h01, 5'h00);
    $display("decode test done");
    for (k = 0; k < 4; k = k + 1) begin
      wr(k[1] ? `BRW_B_REG_ADDR : `BRW_A_REG_ADDR, img(k[1] ? 12'hff4 : 12'hff0, 3'h0, 1'b0, 1'b1, k[0]));
      for (i = 0; i < 18; i = i + 1) begin
        ok = k[1] ? (szt[6*(i/2) +: 6] == 6'h04 && i[0] == 1'b0) : szt[6*(i/2) +: 6] == 6'h01;
        ac((k[1] ? 32'hff400000 : 32'hff000000) + i[0], 1'b1, szt[6*(i/2) +: 6],
           ok ? {1'b1, !k[1], k[1] == 1, k[1] == 1, k[0] == 1} : 5'h00);
      end
    end
    $display("write test done");
    wr(`BRW_B_REG_ADDR, img(12'h123, 3'h5, 1'b1, 1'b1, 1'b1));
    @(posedge clk_i);
    lb_rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    lb_rst_n_i <= 1'b1;
    rdc(`BRW_B_REG_ADDR, 32'hff480004);
    $display("bus reset test done");
    test_done;
  end
endmodule // test_boot_rom_window_decode
